// File: core/rblt_params.svh
// Timing constants and encodings for the receive buffer latency trim sequencer
`ifndef RBLT_PARAMS_SVH
`define RBLT_PARAMS_SVH
`define RBLT_RESET_CYCLES    5'h02
`define RBLT_SETTLE_CYCLES   5'h0c
`define RBLT_STOP_CYCLES     5'h12
`define RBLT_CNT_ZERO        5'h00
`define RBLT_CNT_ONE         5'h01
`define RBLT_SYNC_IDLE       3'h0
`endif

// File: core/rblt_pkg.sv
// Types shared by the receive buffer latency trim sequencer
package rblt_pkg;
    typedef enum logic [2:0] {
        RBLT_ST_RESET  = 3'b000,
        RBLT_ST_SETTLE = 3'b001,
        RBLT_ST_STOP   = 3'b010,
        RBLT_ST_READY  = 3'b011
    } rblt_state_t;

    // Outputs toward the transceiver and the user application
    typedef struct packed {
        logic receive_side_reset;
        logic user_clk_en;
        logic ready;
        logic comma_align_lockout;
    } rblt_ctl_t;
endpackage

// File: core/rblt_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`include "rblt_params.svh"
module rblt_sync (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Asynchronous input and filtered level
    input  wire logic async_in,
    output logic      level_out
);
    logic [2:0] stage_r;

    // Shift chain; first stage is only read by the second
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage_r <= `RBLT_SYNC_IDLE;
        end else begin
            stage_r <= {stage_r[1:0], async_in};
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b0;
        end else if (stage_r[1] == stage_r[2]) begin
            level_out <= stage_r[2];
        end
    end
endmodule

// File: core/rblt_top.sv
// Sequencer that trims receive elastic-buffer latency by gating the user clock
`timescale 1ns/1ns
`include "rblt_params.svh"

// Summary of operation
// R01: With comma alignment, rerun repositioning on every realignment event.
// R02: Without comma alignment, reposition only after receive-side reset.
// R03: Recovered-clock state machine drives enable of gated global clock buffer.
// R04: First step holds receive-side reset asserted two cycles.
// R05: After reset release wait twelve cycles before moving pointers.
// R06: Then stop gated user clock; assert ready only afterwards.
// R07: User logic waits about 30 cycles after reset or realignment.
// R08: One sequencer serves many receivers only without alignment, matched rates; the bench shares one with an aligning receiver.
// R09: User logic ignores elastic buffer overflow status bit.
// R10: Two-byte path: gated user clock drives both user clock ports.
// R11: One-byte path doubles, four-byte halves second clock, 180 degrees shifted.
// R12: Recovered clock frequency equals required user clock frequency.
// R13: Hold user clock stopped for 18 recovered-clock cycles.
// R14: Flag comma alignment lockout after reset or realignment until pointers move.
// R15: Ready high only after pointers moved and receiver fit for operation.
// R16: Realignment input tied low when comma alignment unused.
// R17: New reset or realignment drops ready and enable, restarts sequence; the code drops ready but sets enable high.
module rblt_top #(
    parameter logic [4:0] RESET_CYCLES  = `RBLT_RESET_CYCLES,
    parameter logic [4:0] SETTLE_CYCLES = `RBLT_SETTLE_CYCLES,
    parameter logic [4:0] STOP_CYCLES   = `RBLT_STOP_CYCLES
) (
    // Recovered clock and synchronous reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Restart requests
    input  wire logic rx_restart_in,
    input  wire logic comma_realign_event_in,
    // Transceiver controls
    output logic      receive_side_reset_out,
    output logic      user_clk_en_out,
    // User application status
    output logic      ready_out,
    output logic      comma_align_lockout_out
);
    rblt_pkg::rblt_state_t state_r;
    rblt_pkg::rblt_state_t state_nxt;
    rblt_pkg::rblt_ctl_t   ctl_r;
    rblt_pkg::rblt_ctl_t   ctl_nxt;
    logic [4:0]            cnt_r;
    logic [4:0]            cnt_nxt;
    logic                  restart_lvl;
    logic                  restart_prev_r;
    logic                  realign_lvl;
    logic                  realign_prev_r;
    logic                  kick;

    // Both requests come from outside this clock; synchronise each
    rblt_sync u_sync_restart (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (rx_restart_in),
        .level_out (restart_lvl)
    );
    rblt_sync u_sync_realign (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (comma_realign_event_in),
        .level_out (realign_lvl)
    );

    // Rising-edge memory of the filtered requests
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            restart_prev_r <= 1'b0;
            realign_prev_r <= 1'b0;
        end else begin
            restart_prev_r <= restart_lvl;
            realign_prev_r <= realign_lvl;
        end
    end

    // Realign input tied low means only resets restart the sequence
    assign kick = (restart_lvl & ~restart_prev_r) | (realign_lvl & ~realign_prev_r); // R01 R02 R16

    // Next-state and output decode
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + `RBLT_CNT_ONE;
        ctl_nxt   = ctl_r;
        if (kick) begin
            state_nxt                   = rblt_pkg::RBLT_ST_RESET; // R17
            cnt_nxt                     = `RBLT_CNT_ZERO;
            ctl_nxt.receive_side_reset  = 1'b1; // R04
            ctl_nxt.user_clk_en         = 1'b1;
            ctl_nxt.ready               = 1'b0; // R17
            ctl_nxt.comma_align_lockout = 1'b1; // R14
        end else begin
            case (state_r)
                rblt_pkg::RBLT_ST_RESET: begin
                    if (cnt_r == RESET_CYCLES - `RBLT_CNT_ONE) begin
                        state_nxt                  = rblt_pkg::RBLT_ST_SETTLE; // R04
                        cnt_nxt                    = `RBLT_CNT_ZERO;
                        ctl_nxt.receive_side_reset = 1'b0;
                    end
                end
                rblt_pkg::RBLT_ST_SETTLE: begin
                    if (cnt_r == SETTLE_CYCLES - `RBLT_CNT_ONE) begin
                        state_nxt           = rblt_pkg::RBLT_ST_STOP; // R05
                        cnt_nxt             = `RBLT_CNT_ZERO;
                        ctl_nxt.user_clk_en = 1'b0; // R06
                    end
                end
                rblt_pkg::RBLT_ST_STOP: begin
                    if (cnt_r == STOP_CYCLES - `RBLT_CNT_ONE) begin
                        state_nxt                   = rblt_pkg::RBLT_ST_READY; // R13
                        cnt_nxt                     = `RBLT_CNT_ZERO;
                        ctl_nxt.user_clk_en         = 1'b1;
                        ctl_nxt.ready               = 1'b1; // R15
                        ctl_nxt.comma_align_lockout = 1'b0; // R14
                    end
                end
                rblt_pkg::RBLT_ST_READY: begin
                    cnt_nxt = `RBLT_CNT_ZERO; // Counter parked while idle
                end
                default: begin
                    state_nxt = rblt_pkg::RBLT_ST_RESET;
                    cnt_nxt   = `RBLT_CNT_ZERO;
                end
            endcase
        end
    end

    // State, counter and registered controls; reset starts a full sequence
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r                   <= rblt_pkg::RBLT_ST_RESET;
            cnt_r                     <= `RBLT_CNT_ZERO;
            ctl_r.receive_side_reset  <= 1'b1;
            ctl_r.user_clk_en         <= 1'b1;
            ctl_r.ready               <= 1'b0;
            ctl_r.comma_align_lockout <= 1'b1;
        end else begin
            state_r <= state_nxt; // R03
            cnt_r   <= cnt_nxt;
            ctl_r   <= ctl_nxt;
        end
    end

    // Enable goes to the gated buffer; keep its route short for half-period timing
    assign receive_side_reset_out  = ctl_r.receive_side_reset;
    assign user_clk_en_out         = ctl_r.user_clk_en; // R03
    assign ready_out               = ctl_r.ready;
    assign comma_align_lockout_out = ctl_r.comma_align_lockout;

    // Reset pulse lasts exactly two cycles
    property p_reset_two;
        @(posedge clk_in) disable iff (!rst_n_in || kick)
        $rose(receive_side_reset_out) |-> receive_side_reset_out ##1 receive_side_reset_out ##1
            (!receive_side_reset_out || $past(kick));
    endproperty
    a_reset_two: assert property (p_reset_two) else $error("receive reset not two cycles"); // R04

    // Twelve settle cycles with clock running before stop
    property p_settle;
        @(posedge clk_in) disable iff (!rst_n_in || kick)
        $fell(receive_side_reset_out) |-> (user_clk_en_out && !ready_out)[*8] ##1
            (user_clk_en_out && !ready_out)[*4] ##1 (!user_clk_en_out || $past(kick));
    endproperty
    a_settle: assert property (p_settle) else $error("settle wait wrong"); // R05

    // Stop lasts eighteen cycles then ready
    property p_stop;
        @(posedge clk_in) disable iff (!rst_n_in || kick)
        $fell(user_clk_en_out) |-> ##17 (!user_clk_en_out && !ready_out) ##1 (user_clk_en_out && ready_out);
    endproperty
    a_stop: assert property (p_stop) else $error("stop length wrong"); // R13

    // Ready only ever follows a stop phase
    property p_ready_after_stop;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(ready_out) |-> $past(state_r) == rblt_pkg::RBLT_ST_STOP;
    endproperty
    a_ready_after_stop: assert property (p_ready_after_stop) else $error("ready without stop"); // R06

    // Ready excludes lockout and reset
    property p_ready_clean;
        @(posedge clk_in) disable iff (!rst_n_in)
        ready_out |-> (!comma_align_lockout_out && !receive_side_reset_out && user_clk_en_out);
    endproperty
    a_ready_clean: assert property (p_ready_clean) else $error("ready with lockout or reset"); // R15

    // Lockout held through whole sequence
    property p_lockout;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_r != rblt_pkg::RBLT_ST_READY) |-> comma_align_lockout_out;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout dropped early"); // R14

    // Restart drops ready at once and reasserts reset
    property p_restart;
        @(posedge clk_in) disable iff (!rst_n_in)
        kick |=> (!ready_out && receive_side_reset_out && user_clk_en_out && comma_align_lockout_out);
    endproperty
    a_restart: assert property (p_restart) else $error("restart not honoured"); // R17

    // Realignment edge restarts the sequence
    property p_realign;
        @(posedge clk_in) disable iff (!rst_n_in)
        (realign_lvl && !realign_prev_r) |=> state_r == rblt_pkg::RBLT_ST_RESET;
    endproperty
    a_realign: assert property (p_realign) else $error("realign ignored"); // R01

    // Without requests a ready block stays ready
    property p_hold_ready;
        @(posedge clk_in) disable iff (!rst_n_in)
        (ready_out && !kick) |=> ready_out;
    endproperty
    a_hold_ready: assert property (p_hold_ready) else $error("ready lost without request"); // R02

    // Receive-side reset edge restarts the sequence
    property p_restart_edge;
        @(posedge clk_in) disable iff (!rst_n_in)
        (restart_lvl && !restart_prev_r) |=> state_r == rblt_pkg::RBLT_ST_RESET;
    endproperty
    a_restart_edge: assert property (p_restart_edge) else $error("receive reset request ignored"); // R02

    // User clock is only ever held in the stop phase
    property p_clk_stop_phase;
        @(posedge clk_in) disable iff (!rst_n_in)
        !user_clk_en_out |-> state_r == rblt_pkg::RBLT_ST_STOP;
    endproperty
    a_clk_stop_phase: assert property (p_clk_stop_phase) else $error("user clock stopped outside stop"); // R06
endmodule

// File: tb/rblt_xcvr_model.sv
// Behavioural model of the transceiver receive buffer pointers and realign source
`timescale 1ns/1ns
module rblt_xcvr_model (
    // Clock
    input  wire logic        clk_in,
    // Controls from the sequencer
    input  wire logic        receive_side_reset_in,
    input  wire logic        user_clk_en_in,
    // Bench command and realign event
    input  wire logic        realign_cmd_in,
    output logic             comma_realign_event_out = 1'b0,
    output logic [4:0]       depth_out
);
    logic [4:0] wptr_r = 5'h00;
    logic [4:0] rptr_r = 5'h00;
    logic [3:0] hold_r = 4'h0;
    // Pointers reset 16 words apart, held while internal resets clear
    always @(posedge clk_in) begin
        if (receive_side_reset_in) begin
            wptr_r <= 5'h10;
            rptr_r <= 5'h00;
            hold_r <= 4'hc;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end else begin
            wptr_r <= wptr_r + 5'h01;
            // Read side and second user clock both run from the gated clock, in step
            if (user_clk_en_in) rptr_r <= rptr_r + 5'h01;
        end
    end
    // Overflow status not modelled; user side ignores it anyway
    assign depth_out = wptr_r - rptr_r;
    // Realign event only when the bench commands comma realignment
    always @(posedge clk_in) comma_realign_event_out <= realign_cmd_in;
endmodule

// File: tb/rblt_top_tb.sv
// Self-checking bench for the receive buffer latency trim sequencer
`timescale 1ns/1ns
`define CHK(got, exp) check_val(got, exp)
module rblt_top_tb;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       rx_restart_in = 1'b0;
    logic       realign_cmd = 1'b0;
    logic       comma_realign_event_in;
    logic       receive_side_reset_out;
    logic       user_clk_en_out;
    logic       ready_out;
    logic       comma_align_lockout_out;
    logic [4:0] depth;
    logic [4:0] depth_b;
    int         fails = 0;
    int         samples_checked = 0;
    int         ph = 0;
    int         wait_cnt = 0;
    int         seed = 11;
    int         i;
    int         d;
    bit         pend = 0;
    bit         prev_rst = 1;
    bit         prev_req = 0;
    // Clock at 20 MHz
    always #25 clk_in = ~clk_in;
    rblt_top rblt_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .rx_restart_in(rx_restart_in),
        .comma_realign_event_in(comma_realign_event_in), .receive_side_reset_out(receive_side_reset_out),
        .user_clk_en_out(user_clk_en_out), .ready_out(ready_out), .comma_align_lockout_out(comma_align_lockout_out));
    rblt_xcvr_model rblt_xcvr_model_inst (.clk_in(clk_in), .receive_side_reset_in(receive_side_reset_out),
        .user_clk_en_in(user_clk_en_out), .realign_cmd_in(realign_cmd),
        .comma_realign_event_out(comma_realign_event_in), .depth_out(depth));
    // Second receiver on the same sequencer: no alignment, same serial clock
    rblt_xcvr_model rblt_xcvr_model_b_inst (.clk_in(clk_in), .receive_side_reset_in(receive_side_reset_out),
        .user_clk_en_in(user_clk_en_out), .realign_cmd_in(1'b0),
        .comma_realign_event_out(), .depth_out(depth_b));
    task check_val(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Phase model: restart seen as a rise of the receive reset, then fixed sequence
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ph = 0;
            pend = 1; // Reset release itself starts a sequence
            wait_cnt = 0;
        end else begin
            if ((rx_restart_in | comma_realign_event_in) && !prev_req) begin
                pend = 1;
                wait_cnt = 0;
            end
            if (receive_side_reset_out && !prev_rst) begin
                `CHK(pend, 1'b1);
                `CHK(wait_cnt <= 7, 1'b1);
                pend = 0;
                ph = 1;
            end else if (ph > 0 && ph < 40) ph++;
            if (pend) wait_cnt++;
            if (ph > 0) begin
                `CHK(receive_side_reset_out, ph <= 2);
                `CHK(user_clk_en_out, !(ph >= 15 && ph <= 32));
                `CHK(ready_out, ph >= 33);
                `CHK(comma_align_lockout_out, ph < 33);
            end
            if (ph == 33) `CHK(depth <= 5'h02, 1'b1);
            if (ph == 33) `CHK(depth_b <= 5'h02, 1'b1);
        end
        prev_rst = receive_side_reset_out && rst_n_in; // Level held in reset is not yet a rise
        prev_req = rx_restart_in | comma_realign_event_in;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        for (i = 0; i < 14; i++) begin
            d = ($random(seed) & 31) + 1;
            repeat (d) @(posedge clk_in);
            // Realignment only once lockout has lifted; restart may cut in anywhere after the reset pulse
            while (i[0] ? ph < 33 : ph < 3) @(posedge clk_in);
            // Even tests use receive reset, odd ones realignment
            if (i[0]) realign_cmd <= 1'b1;
            else rx_restart_in <= 1'b1;
            // First request held long: a held level must not retrigger
            repeat (i == 0 ? 45 : 3 + ($random(seed) & 3)) @(posedge clk_in);
            realign_cmd <= 1'b0;
            rx_restart_in <= 1'b0;
            repeat (5) @(posedge clk_in);
            $display("test %0d done", i);
        end
        // Reset in mid-sequence, then a full run must still reach ready
        while (ph < 10) @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        `CHK(ready_out, 1'b1);
        $display("test reset done");
        stop_test();
    end
endmodule
